// ===== nal_alu_core.sv
// Purpose: nibble alu, status flags, decimal adjust and memory address control
// Assumes: memory read data appear in the same cycle as the read strobe
// Notes: system locations are held here; writes to them never reach the memory
`timescale 1ns/1ps
module nal_alu_core
  import nal_pkg::*;
(
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  // register port
  input  wire logic [REG_AW-1:0] i_reg_addr,
  input  wire logic [NIB_W-1:0]  i_reg_wdata,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  output logic      [NIB_W-1:0]  o_reg_rdata,
  // instruction from sequencer
  input  wire logic              i_start,
  input  wire nal_op_type        i_opcode,
  input  wire logic [BANK_W-1:0] i_bank,
  input  wire logic [ROW_W-1:0]  i_m_row,
  input  wire logic [NIB_W-1:0]  i_m_col,
  input  wire logic [NIB_W-1:0]  i_r_col,
  input  wire logic [NIB_W-1:0]  i_imm,
  output logic                   o_busy,
  output logic                   o_done,
  output logic                   o_skip,
  // data memory
  output logic      [ADDR_W-1:0] o_mem_addr,
  output logic                   o_mem_rd,
  output logic                   o_mem_wr,
  output logic      [NIB_W-1:0]  o_mem_wdata,
  input  wire logic [NIB_W-1:0]  i_mem_rdata
);

  nal_state_type state;
  nal_op_type    op;
  logic [BANK_W-1:0] bank;
  logic [ROW_W-1:0]  m_row;
  logic [NIB_W-1:0]  m_col;
  logic [NIB_W-1:0]  r_col;
  logic [NIB_W-1:0]  imm;

  // temporaries, not mapped on the register port
  logic [NIB_W-1:0] tmp_a;
  logic [NIB_W-1:0] tmp_b;

  // pointer and modifier state
  logic [BANK_W-1:0] ptr_bank;
  logic [ROW_W-1:0]  ptr_row;
  logic              decimal_flag;
  logic [NIB_W-1:0]  ix_col;
  logic [ROW_W-1:0]  ix_row;
  logic [ROW_W-1:0]  mp_row;
  logic [BANK_W-1:0] mp_bank;
  logic              mp_en;

  // status word flags
  logic compare_only_flag;
  logic carry_flag;
  logic zero_flag;
  logic index_enable_flag;

  // decode
  logic need_r;
  logic need_m;
  logic imm_form;
  logic wr_to_r;
  logic wr_en;
  logic is_arith;
  logic is_sub;
  logic with_carry;

  // datapath
  logic [NIB_W-1:0]  opnd_x;
  logic [NIB_W-1:0]  opnd_y;
  logic [NIB_W-1:0]  sum;
  logic              sum_carry;
  logic [NIB_W-1:0]  result;
  logic              skip_cond;
  logic              store;
  logic [ADDR_W-1:0] gr_addr;
  logic [ADDR_W-1:0] m_addr;
  logic [ADDR_W-1:0] ind_addr;
  logic [ADDR_W-1:0] dest_addr;
  logic              dest_sys;
  logic [NIB_W-1:0]  cap_data;

  function automatic logic is_sys(input logic [ADDR_W-1:0] a, input logic [NIB_W-1:0] c);
    return (a[NIB_W+ROW_W-1:NIB_W] == SYS_ROW) && (a[NIB_W-1:0] == c);
  endfunction

  function automatic logic sys_loc(input logic [ADDR_W-1:0] a);
    return is_sys(a, COL_PTR_BANK) || is_sys(a, COL_PTR_ROW) || is_sys(a, COL_STATUS);
  endfunction

  function automatic logic [NIB_W-1:0] sys_value(input logic [NIB_W-1:0] c);
    logic [NIB_W-1:0] v;
    v = NIB_ZERO;
    if (c == COL_PTR_BANK)
      v = ptr_bank;
    else if (c == COL_PTR_ROW)
      v = {ptr_row, decimal_flag};
    else if (c == COL_STATUS)
      v = {compare_only_flag, carry_flag, zero_flag, index_enable_flag};
    return v;
  endfunction

  always_comb
  begin
    need_r = 1'b0;
    need_m = 1'b1;
    imm_form = 1'b0;
    wr_to_r = 1'b0;
    wr_en = 1'b1;
    case (op)
      OP_ADD_RM, OP_ADD_WITH_CARRY_RM, OP_SUB_RM, OP_SUBB_RM,
      OP_OR_RM, OP_AND_RM, OP_XOR_RM, OP_LOAD_R:
      begin
        need_r = 1'b1;
        wr_to_r = 1'b1;
      end
      OP_WRITE_BACK, OP_IND_WRITE, OP_IND_READ:
        need_r = 1'b1;
      OP_ROTATE:
      begin
        need_r = 1'b1;
        need_m = 1'b0;
        wr_to_r = 1'b1;
      end
      OP_SET_M:
        need_m = 1'b0;
      OP_BITS_TRUE, OP_BITS_FALSE, OP_EQUAL, OP_UNEQUAL, OP_GREATER_EQ, OP_LESS:
      begin
        imm_form = 1'b1;
        wr_en = 1'b0;
      end
      default:
        imm_form = 1'b1;
    endcase
  end

  always_comb
  begin
    is_arith = (op inside {OP_ADD_RM, OP_ADD_MI, OP_ADD_WITH_CARRY_RM, OP_ADD_WITH_CARRY_MI,
                           OP_SUB_RM, OP_SUB_MI, OP_SUBB_RM, OP_SUBB_MI});
    is_sub = (op inside {OP_SUB_RM, OP_SUB_MI, OP_SUBB_RM, OP_SUBB_MI});
    with_carry = (op inside {OP_ADD_WITH_CARRY_RM, OP_ADD_WITH_CARRY_MI, OP_SUBB_RM, OP_SUBB_MI});
  end

  // general register row follows the pointer, not the current bank
  assign gr_addr = {ptr_bank, ptr_row, r_col};

  // index or-modifies the operand address, except for rotate
  assign m_addr = (index_enable_flag && (op != OP_ROTATE))
                  ? {bank, m_row | ix_row, m_col | ix_col}
                  : {bank, m_row, m_col};

  // row pointer replaces bank and row only for indirect moves
  always_comb
  begin
    ind_addr = mp_en ? {mp_bank, mp_row, tmp_b} : {bank, m_row, tmp_b};
    if (index_enable_flag)
      ind_addr = ind_addr | {{BANK_W{1'b0}}, ix_row, ix_col};
  end

  // x is the destination side operand, y the source side
  assign opnd_x = imm_form ? tmp_a : tmp_b;
  assign opnd_y = imm_form ? imm : tmp_a;

  nal_bcd_adder u_adder (
    .i_x       (opnd_x),
    .i_y       (opnd_y),
    .i_carry   (with_carry && carry_flag),
    .i_sub     (is_sub),
    .i_decimal (decimal_flag),
    .o_sum     (sum),
    .o_carry   (sum_carry)
  );

  always_comb
  begin
    result = tmp_a;
    skip_cond = 1'b0;
    case (op)
      OP_OR_RM, OP_OR_MI:
        result = opnd_x | opnd_y;
      OP_AND_RM, OP_AND_MI:
        result = opnd_x & opnd_y;
      OP_XOR_RM, OP_XOR_MI:
        result = opnd_x ^ opnd_y;
      OP_BITS_TRUE:
        skip_cond = ((tmp_a & imm) == imm);
      OP_BITS_FALSE:
        skip_cond = ((tmp_a & imm) == NIB_ZERO);
      OP_EQUAL:
        skip_cond = (tmp_a == imm);
      OP_UNEQUAL:
        skip_cond = (tmp_a != imm);
      OP_GREATER_EQ:
        skip_cond = (tmp_a >= imm);
      OP_LESS:
        skip_cond = (tmp_a < imm);
      OP_WRITE_BACK, OP_IND_WRITE:
        result = (op == OP_WRITE_BACK) ? tmp_b : tmp_a;
      OP_SET_M:
        result = imm;
      OP_ROTATE:
        result = {carry_flag, tmp_b[NIB_W-1:1]};
      default:
        result = is_arith ? sum : tmp_a;
    endcase
  end

  always_comb
  begin
    if (wr_to_r)
      dest_addr = gr_addr;
    else if (op == OP_IND_WRITE)
      dest_addr = ind_addr;
    else
      dest_addr = m_addr;
  end

  // compare-only arithmetic computes flags but stores nothing
  assign store = wr_en && !(is_arith && compare_only_flag);
  assign dest_sys = sys_loc(dest_addr);
  // a process so that flag and pointer changes reach the captured value
  always_comb
  begin
    if (sys_loc(o_mem_addr))
      cap_data = sys_value(o_mem_addr[NIB_W-1:0]);
    else
      cap_data = i_mem_rdata;
  end

  // sequencer
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      state <= S_IDLE;
    else
    begin
      case (state)
        S_IDLE:
        begin
          if (i_start && (i_opcode inside {OP_WRITE_BACK, OP_LOAD_R, OP_ADD_RM,
              OP_ADD_WITH_CARRY_RM, OP_SUB_RM, OP_SUBB_RM, OP_OR_RM, OP_AND_RM, OP_XOR_RM,
              OP_IND_WRITE, OP_IND_READ, OP_ROTATE}))
            state <= S_READ_R;
          else if (i_start && (i_opcode == OP_SET_M))
            state <= S_EXEC;
          else if (i_start)
            state <= S_READ_M;
        end
        S_READ_R:
          state <= S_CAP_R;
        S_CAP_R:
          state <= need_m ? S_ISSUE_M : S_EXEC;
        S_ISSUE_M:
          state <= S_READ_M;
        S_READ_M:
          state <= S_CAP_M;
        S_CAP_M:
          state <= S_EXEC;
        default:
          state <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      op <= OP_SET_M;
      bank <= '0;
      m_row <= '0;
      m_col <= '0;
      r_col <= '0;
      imm <= '0;
    end
    else if (i_start && (state == S_IDLE))
    begin
      op <= i_opcode;
      bank <= i_bank;
      m_row <= i_m_row;
      m_col <= i_m_col;
      r_col <= i_r_col;
      imm <= i_imm;
    end
  end

  // temporaries load only from memory reads
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      tmp_a <= '0;
      tmp_b <= '0;
    end
    else if (state == S_CAP_R)
      tmp_b <= cap_data;
    else if (state == S_CAP_M)
      tmp_a <= cap_data;
  end

  // memory strobes, address and data
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_mem_addr <= '0;
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      o_mem_wdata <= '0;
    end
    else
    begin
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      if (state == S_READ_R)
      begin
        o_mem_addr <= gr_addr;
        o_mem_rd <= 1'b1;
      end
      else if (state == S_READ_M)
      begin
        o_mem_addr <= (op == OP_IND_READ) ? ind_addr : m_addr;
        o_mem_rd <= 1'b1;
      end
      else if ((state == S_EXEC) && store && !dest_sys)
      begin
        o_mem_addr <= dest_addr;
        o_mem_wr <= 1'b1;
        o_mem_wdata <= result;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_skip <= 1'b0;
    end
    else
    begin
      o_done <= (state == S_EXEC);
      o_skip <= (state == S_EXEC) && skip_cond;
      if (state == S_EXEC)
        o_busy <= 1'b0;
      else if (i_start && (state == S_IDLE))
        o_busy <= 1'b1;
    end
  end

  // status flags; a store into the status word beats the flag update
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      compare_only_flag <= 1'b0;
      carry_flag <= 1'b0;
      zero_flag <= 1'b0;
      index_enable_flag <= 1'b0;
    end
    else
    begin
      if ((state == S_EXEC) && is_arith)
      begin
        carry_flag <= sum_carry;
        if (compare_only_flag)
          zero_flag <= zero_flag && (sum == NIB_ZERO);
        else
          zero_flag <= (sum == NIB_ZERO);
      end
      else if ((state == S_EXEC) && (op == OP_ROTATE))
        carry_flag <= tmp_b[0];
      if ((state == S_EXEC) && store && is_sys(dest_addr, COL_STATUS))
      begin
        compare_only_flag <= result[BIT_COMPARE];
        carry_flag <= result[BIT_CARRY];
        zero_flag <= result[BIT_ZERO];
        index_enable_flag <= result[BIT_INDEX];
      end
      if (i_reg_wr && (i_reg_addr == OFS_STATUS))
      begin
        compare_only_flag <= i_reg_wdata[BIT_COMPARE];
        carry_flag <= i_reg_wdata[BIT_CARRY];
        zero_flag <= i_reg_wdata[BIT_ZERO];
        index_enable_flag <= i_reg_wdata[BIT_INDEX];
      end
    end
  end

  // pointer, decimal flag and modifiers; software write wins a same-cycle clash
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      ptr_bank <= '0;
      ptr_row <= '0;
      decimal_flag <= 1'b0;
      ix_col <= '0;
      ix_row <= '0;
      mp_row <= '0;
      mp_bank <= '0;
      mp_en <= 1'b0;
    end
    else
    begin
      if ((state == S_EXEC) && store && is_sys(dest_addr, COL_PTR_BANK))
        ptr_bank <= result;
      if ((state == S_EXEC) && store && is_sys(dest_addr, COL_PTR_ROW))
      begin
        ptr_row <= result[NIB_W-1:1];
        decimal_flag <= result[BIT_DECIMAL];
      end
      if (i_reg_wr)
      begin
        if (i_reg_addr == OFS_PTR_BANK)
          ptr_bank <= i_reg_wdata;
        else if (i_reg_addr == OFS_PTR_ROW)
        begin
          ptr_row <= i_reg_wdata[NIB_W-1:1];
          decimal_flag <= i_reg_wdata[BIT_DECIMAL];
        end
        else if (i_reg_addr == OFS_IX_COL)
          ix_col <= i_reg_wdata;
        else if (i_reg_addr == OFS_IX_ROW)
          ix_row <= i_reg_wdata[ROW_W-1:0];
        else if (i_reg_addr == OFS_MP_ROW)
          mp_row <= i_reg_wdata[ROW_W-1:0];
        else if (i_reg_addr == OFS_MP_BANK)
          mp_bank <= i_reg_wdata;
        else if (i_reg_addr == OFS_MP_EN)
          mp_en <= i_reg_wdata[0];
      end
    end
  end

  // register read, one cycle later; unmapped reads as zero
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_reg_rdata <= '0;
    else if (i_reg_rd)
    begin
      if (i_reg_addr == OFS_PTR_BANK)
        o_reg_rdata <= sys_value(COL_PTR_BANK);
      else if (i_reg_addr == OFS_PTR_ROW)
        o_reg_rdata <= sys_value(COL_PTR_ROW);
      else if (i_reg_addr == OFS_STATUS)
        o_reg_rdata <= sys_value(COL_STATUS);
      else if (i_reg_addr == OFS_IX_COL)
        o_reg_rdata <= ix_col;
      else if (i_reg_addr == OFS_IX_ROW)
        o_reg_rdata <= {1'b0, ix_row};
      else if (i_reg_addr == OFS_MP_ROW)
        o_reg_rdata <= {1'b0, mp_row};
      else if (i_reg_addr == OFS_MP_BANK)
        o_reg_rdata <= mp_bank;
      else if (i_reg_addr == OFS_MP_EN)
        o_reg_rdata <= {3'h0, mp_en};
      else
        o_reg_rdata <= NIB_ZERO;
    end
    else
      o_reg_rdata <= NIB_ZERO;
  end

endmodule

// ===== nal_pkg.sv
// Purpose: shared constants and types of the nibble alu and flag logic
// Assumes: one core clock, data memory address is bank/row/column
// Notes: system locations sit in row 7 of every bank
package nal_pkg;

  localparam int NIB_W  = 4;
  localparam int BANK_W = 4;
  localparam int ROW_W  = 3;
  localparam int ADDR_W = BANK_W + ROW_W + NIB_W;
  localparam int REG_AW = ROW_W + NIB_W;

  // system register locations (row, column)
  localparam logic [ROW_W-1:0] SYS_ROW      = 3'h7;
  localparam logic [NIB_W-1:0] COL_PTR_BANK = 4'hD;
  localparam logic [NIB_W-1:0] COL_PTR_ROW  = 4'hE;
  localparam logic [NIB_W-1:0] COL_STATUS   = 4'hF;

  // register port offsets
  localparam logic [REG_AW-1:0] OFS_PTR_BANK = 7'h7D;
  localparam logic [REG_AW-1:0] OFS_PTR_ROW  = 7'h7E;
  localparam logic [REG_AW-1:0] OFS_STATUS   = 7'h7F;
  localparam logic [REG_AW-1:0] OFS_IX_COL   = 7'h70;
  localparam logic [REG_AW-1:0] OFS_IX_ROW   = 7'h71;
  localparam logic [REG_AW-1:0] OFS_MP_ROW   = 7'h72;
  localparam logic [REG_AW-1:0] OFS_MP_BANK  = 7'h73;
  localparam logic [REG_AW-1:0] OFS_MP_EN    = 7'h74;

  // status word and pointer row bit positions
  localparam int BIT_COMPARE = 3;
  localparam int BIT_CARRY   = 2;
  localparam int BIT_ZERO    = 1;
  localparam int BIT_INDEX   = 0;
  localparam int BIT_DECIMAL = 0;

  localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;
  localparam logic [NIB_W:0]   BCD_MAX  = 5'h09;
  localparam logic [NIB_W:0]   BCD_FIX  = 5'h06;

  // immediate forms exist only against memory, never against the register
  typedef enum logic [4:0] {
    OP_ADD_RM, OP_ADD_MI, OP_ADD_WITH_CARRY_RM, OP_ADD_WITH_CARRY_MI,
    OP_SUB_RM, OP_SUB_MI, OP_SUBB_RM, OP_SUBB_MI,
    OP_OR_RM, OP_OR_MI, OP_AND_RM, OP_AND_MI, OP_XOR_RM, OP_XOR_MI,
    OP_BITS_TRUE, OP_BITS_FALSE, OP_EQUAL, OP_UNEQUAL, OP_GREATER_EQ, OP_LESS,
    OP_LOAD_R, OP_WRITE_BACK, OP_SET_M, OP_IND_WRITE, OP_IND_READ, OP_ROTATE
  } nal_op_type;

  typedef enum logic [2:0] {
    S_IDLE, S_READ_R, S_CAP_R, S_ISSUE_M, S_READ_M, S_CAP_M, S_EXEC
  } nal_state_type;

endpackage

// ===== nal_bcd_adder.sv
// Purpose: four bit add or subtract with optional decimal adjustment
// Assumes: decimal operands are valid bcd digits
// Notes: purely combinational; carry out means carry on add, borrow on sub
`timescale 1ns/1ps
module nal_bcd_adder
  import nal_pkg::*;
(
  // operands
  input  wire logic [NIB_W-1:0] i_x,
  input  wire logic [NIB_W-1:0] i_y,
  input  wire logic             i_carry,
  input  wire logic             i_sub,
  input  wire logic             i_decimal,
  // result
  output logic      [NIB_W-1:0] o_sum,
  output logic                  o_carry
);

  logic [NIB_W:0] raw;
  logic [NIB_W:0] adj;

  always_comb
  begin
    adj = '0;
    if (i_sub)
    begin
      raw = {1'b0, i_x} - {1'b0, i_y} - {{NIB_W{1'b0}}, i_carry};
      o_carry = raw[NIB_W];
      adj = raw - ((i_decimal && raw[NIB_W]) ? BCD_FIX : '0);
    end
    else
    begin
      raw = {1'b0, i_x} + {1'b0, i_y} + {{NIB_W{1'b0}}, i_carry};
      o_carry = raw[NIB_W] || (i_decimal && (raw > BCD_MAX));
      adj = raw + ((i_decimal && (raw > BCD_MAX)) ? BCD_FIX : '0);
    end
    o_sum = adj[NIB_W-1:0];
  end

endmodule

// ===== nal_alu_core_assertions.sv
// Purpose: port assertions for the nibble alu core
// Assumes: one clock, synchronous active high reset
// Notes: bound to every instance of the core
`timescale 1ns/1ps
module nal_alu_core_checker
  import nal_pkg::*;
(
  // clock and reset
  input wire logic              i_clk,
  input wire logic              i_reset,
  // register port
  input wire logic [REG_AW-1:0] i_reg_addr,
  input wire logic [NIB_W-1:0]  i_reg_wdata,
  input wire logic              i_reg_wr,
  input wire logic              i_reg_rd,
  input wire logic [NIB_W-1:0]  o_reg_rdata,
  // sequencer and memory
  input wire logic              i_start,
  input wire logic              o_busy,
  input wire logic              o_done,
  input wire logic              o_skip,
  input wire logic              o_mem_rd,
  input wire logic              o_mem_wr
);
  logic mapped;
  assign mapped = i_reg_addr inside {[7'h70:7'h74], [7'h7D:7'h7F]};

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  property p_take;
    i_start && !o_busy |=> o_busy;
  endproperty
  a_take: assert property (p_take) else $error("start not taken");
  property p_lat;
    i_start && !o_busy |-> ##[2:8] o_done;
  endproperty
  a_lat: assert property (p_lat) else $error("instruction never ended");
  property p_pulse;
    o_done |=> !o_done;
  endproperty
  a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
  property p_busy;
    o_busy && !o_done |=> o_busy || o_done;
  endproperty
  a_busy: assert property (p_busy) else $error("busy fell without done");
  property p_skip;
    o_skip |-> o_done;
  endproperty
  a_skip: assert property (p_skip) else $error("skip outside done");
  property p_wr;
    o_mem_wr |-> o_done && !o_mem_rd;
  endproperty
  a_wr: assert property (p_wr) else $error("memory write off the last cycle");
  property p_rd;
    o_mem_rd |-> o_busy;
  endproperty
  a_rd: assert property (p_rd) else $error("memory read while idle");
  property p_idle;
    !i_reg_rd |=> o_reg_rdata == 4'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("read data without strobe");
  property p_unmap;
    i_reg_rd && !mapped |=> o_reg_rdata == 4'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_ptr_row;
    (i_reg_wr && i_reg_addr == OFS_PTR_ROW && !o_busy) ##1 !i_reg_wr
      ##1 (i_reg_rd && i_reg_addr == OFS_PTR_ROW) |=> o_reg_rdata == $past(i_reg_wdata, 3);
  endproperty
  a_ptr_row: assert property (p_ptr_row) else $error("pointer row readback");

  c_skip: cover property (o_skip);
  c_wr: cover property (o_mem_wr && o_done);
  c_take: cover property (i_start && !o_busy);
endmodule

bind nal_alu_core nal_alu_core_checker u_nal_alu_core_checker (
  .i_clk(i_clk), .i_reset(i_reset), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .i_start(i_start), .o_busy(o_busy), .o_done(o_done),
  .o_skip(o_skip), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr)
);

// ===== nal_mem_model.sv
// Purpose: behavioural data memory facing the alu core
// Assumes: read data stand while the read strobe is high
// Notes: bench preloads and inspects mem directly
`timescale 1ns/1ps
module nal_mem_model
  import nal_pkg::*;
(
  // clock
  input  wire logic              i_clk,
  // access
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_rd,
  input  wire logic              i_wr,
  input  wire logic [NIB_W-1:0]  i_wdata,
  output logic      [NIB_W-1:0]  o_rdata
);
  logic [NIB_W-1:0] mem [0:2047];

  // the core captures at the end of its strobe cycle, so reads answer at once;
  // without the strobe the bus shows the inverse so stale data never match
  assign o_rdata = i_rd ? mem[i_addr] : ~mem[i_addr];

  // plain always so the bench may preload the array
  always @(posedge i_clk)
  begin
    if (i_wr)
      mem[i_addr] <= i_wdata;
  end
endmodule

// ===== nibble_alu_flag_logic_test.sv
// Purpose: self-checking bench for the nibble alu core
// Assumes: register row 2 of bank 1, operand bank 2 row 1 col 5
// Notes: ordinary operations come from the row table
`timescale 1ns/1ps
module nibble_alu_flag_logic_test
  import nal_pkg::*;
;
  typedef struct packed {
    nal_op_type op;
    logic [3:0] sf, dec, rv, mv, imm, er, em, ef, sk;
  } nal_row_type;
  localparam logic [ADDR_W-1:0] RA = 11'h0A3;
  localparam logic [ADDR_W-1:0] MA = 11'h115;
  logic i_clk = 1'b0, i_reset = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_start = 1'b0;
  logic [REG_AW-1:0] i_reg_addr = 7'h00;
  logic [NIB_W-1:0] i_reg_wdata = 4'h0, i_m_col = 4'h0, i_imm = 4'h0, i_bank = 4'h0;
  logic [ROW_W-1:0] i_m_row = 3'h0;
  nal_op_type i_opcode = OP_ADD_RM;
  logic [NIB_W-1:0] o_reg_rdata, o_mem_wdata, i_mem_rdata, v;
  logic [ADDR_W-1:0] o_mem_addr;
  logic o_busy, o_done, o_skip, o_mem_rd, o_mem_wr, done_seen, skip_seen;
  int num_errors = 0, checks = 0, cycles = 0;
  nal_row_type r;
  logic [6:0] ra [8] = '{7'h70, 7'h71, 7'h72, 7'h73, 7'h74, 7'h7D, 7'h7E, 7'h7F};
  logic [3:0] rm [8] = '{4'hF, 4'h7, 4'h7, 4'hF, 4'h1, 4'hF, 4'hF, 4'hF};
  // fields: status, decimal, r, m, imm, r after, m after, status after, skip
  nal_row_type rows [27] = '{
    {OP_ADD_RM, 36'h007900960}, {OP_ADD_RM, 36'h015803840}, {OP_SUB_RM, 36'h00350E540},
    {OP_SUBB_RM, 36'h405202200}, {OP_ADD_WITH_CARRY_RM, 36'h402306300}, {OP_ADD_RM, 36'hA088088E0},
    {OP_ADD_RM, 36'hA01201280}, {OP_SUB_MI, 36'h011351840}, {OP_AND_RM, 36'h60CA08A60},
    {OP_OR_MI, 36'h0005A0F00}, {OP_XOR_RM, 36'h00F50A500}, {OP_EQUAL, 36'h000550501},
    {OP_UNEQUAL, 36'h000550500}, {OP_GREATER_EQ, 36'h000340300}, {OP_LESS, 36'h000340301},
    {OP_BITS_TRUE, 36'h000750701}, {OP_BITS_FALSE, 36'h000870801}, {OP_LOAD_R, 36'h000909900},
    {OP_WRITE_BACK, 36'h006006600}, {OP_SET_M, 36'h0000C0C00}, {OP_ROTATE, 36'h205002060},
    {OP_ADD_MI, 36'h000880060}, {OP_SUBB_MI, 36'h410000940}, {OP_ADD_WITH_CARRY_MI, 36'h410900060},
    {OP_AND_MI, 36'h000630200}, {OP_OR_RM, 36'h005A0FA00}, {OP_XOR_MI, 36'h000F50A00}};

  nal_alu_core u_nal_alu_core (
    .i_clk(i_clk), .i_reset(i_reset), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_start(i_start),
    .i_opcode(i_opcode), .i_bank(i_bank), .i_m_row(i_m_row), .i_m_col(i_m_col),
    .i_r_col(4'h3), .i_imm(i_imm), .o_busy(o_busy), .o_done(o_done), .o_skip(o_skip),
    .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
    .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata));
  nal_mem_model u_nal_mem_model (
    .i_clk(i_clk), .i_addr(o_mem_addr), .i_rd(o_mem_rd), .i_wr(o_mem_wr),
    .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));

  always #12.5 i_clk = ~i_clk;

  task automatic tally_and_finish();
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // strobe low for one cycle after each access, so no same-step reassign
  task automatic wr(input logic [6:0] a, input logic [3:0] d);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic rd(input logic [6:0] a, output logic [3:0] d);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    @(negedge i_clk);
    d = o_reg_rdata;
    @(posedge i_clk);
  endtask

  task automatic op(input nal_op_type c, input logic [3:0] b, input logic [2:0] w,
                    input logic [3:0] col, input logic [3:0] im);
    int n;
    i_start <= 1'b1;
    i_opcode <= c;
    i_bank <= b;
    i_m_row <= w;
    i_m_col <= col;
    i_imm <= im;
    @(posedge i_clk);
    i_start <= 1'b0;
    done_seen = 1'b0;
    for (n = 0; n < 12 && !done_seen; n++)
    begin
      @(negedge i_clk);
      done_seen = (o_done === 1'b1);
      skip_seen = o_skip;
    end
    chk({3'h0, done_seen}, 4'h1);
    @(posedge i_clk);
  endtask

  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    for (int i = 0; i < 8; i++)
    begin
      rd(ra[i], v);
      chk(v, 4'h0);
      wr(ra[i], 4'hF);
      rd(ra[i], v);
      chk(v, rm[i]);
    end
    wr(7'h10, 4'hF);
    rd(7'h10, v);
    chk(v, 4'h0);
    // second reset mid-run must clear the status word written above
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    rd(7'h7F, v);
    chk(v, 4'h0);
    wr(7'h7D, 4'h1);
    foreach (rows[i])
    begin
      r = rows[i];
      wr(7'h7F, r.sf);
      wr(7'h7E, {3'h2, r.dec[0]});
      u_nal_mem_model.mem[RA] = r.rv;
      u_nal_mem_model.mem[MA] = r.mv;
      op(r.op, 4'h2, 3'h1, 4'h5, r.imm);
      chk({3'h0, skip_seen}, r.sk);
      rd(7'h7F, v);
      chk(v, r.ef);
      chk(u_nal_mem_model.mem[RA], r.er);
      chk(u_nal_mem_model.mem[MA], r.em);
    end
    wr(7'h7E, 4'h4);
    wr(7'h7F, 4'h4);
    op(OP_ADD_MI, 4'h0, 3'h7, 4'hF, 4'hC);
    rd(7'h7F, v);
    chk(v, 4'h0);
    wr(7'h7F, 4'h1);
    wr(7'h70, 4'h2);
    u_nal_mem_model.mem[11'h117] = 4'h4;
    u_nal_mem_model.mem[MA] = 4'h9;
    op(OP_ADD_MI, 4'h2, 3'h1, 4'h5, 4'h1);
    wr(7'h7F, 4'h0);
    chk(u_nal_mem_model.mem[11'h117], 4'h5);
    chk(u_nal_mem_model.mem[MA], 4'h9);
    wr(7'h72, 4'h4);
    wr(7'h73, 4'h3);
    wr(7'h74, 4'h1);
    u_nal_mem_model.mem[RA] = 4'h6;
    u_nal_mem_model.mem[11'h1C6] = 4'h0;
    op(OP_IND_WRITE, 4'h2, 3'h1, 4'h5, 4'h0);
    op(OP_ADD_MI, 4'h2, 3'h1, 4'h5, 4'h1);
    wr(7'h74, 4'h0);
    chk(u_nal_mem_model.mem[11'h1C6], 4'h9);
    chk(u_nal_mem_model.mem[MA], 4'hA);
    wr(7'h74, 4'h1);
    u_nal_mem_model.mem[11'h1C6] = 4'h7;
    op(OP_IND_READ, 4'h2, 3'h1, 4'h5, 4'h0);
    wr(7'h74, 4'h0);
    chk(u_nal_mem_model.mem[MA], 4'h7);
    chk(u_nal_mem_model.mem[RA], 4'h6);
    tally_and_finish();
  end
endmodule
